// ==== verilog/ppo_pkg.sv ====
package ppo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // carriers: index 0 is the first port, 3 the fourth
    typedef logic [3:0][7:0] ppo_port_bus_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } ppo_av_req_t;

    typedef struct packed {
        ppo_port_bus_t outAssign;
        ppo_port_bus_t oeTerm;
        logic [2:0][7:0] macroOut;
        logic [7:0]      chipSel;
    } ppo_logic_out_t;

    typedef struct packed {
        logic [2:0][7:0] macroIn;
        logic [7:0]      directIn;
    } ppo_logic_in_t;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_IN_A   = 6'h00;
    localparam logic [5:0] IDX_IN_B   = 6'h01;
    localparam logic [5:0] IDX_CTL_A  = 6'h02;
    localparam logic [5:0] IDX_CTL_B  = 6'h03;
    localparam logic [5:0] IDX_OUT_A  = 6'h04;
    localparam logic [5:0] IDX_OUT_B  = 6'h05;
    localparam logic [5:0] IDX_DIR_A  = 6'h06;
    localparam logic [5:0] IDX_DIR_B  = 6'h07;
    localparam logic [5:0] IDX_IN_C   = 6'h10;
    localparam logic [5:0] IDX_IN_D   = 6'h11;
    localparam logic [5:0] IDX_OUT_C  = 6'h12;
    localparam logic [5:0] IDX_OUT_D  = 6'h13;
    localparam logic [5:0] IDX_DIR_C  = 6'h14;
    localparam logic [5:0] IDX_DIR_D  = 6'h15;

    // implemented pin positions per port
    localparam ppo_port_bus_t PORT_MASK = {8'h06, 8'h9C, 8'hFF, 8'hFF};
    localparam logic [7:0]    REG_RESET = 8'h00;
    localparam logic [31:0]   READ_ZERO = 32'h0000_0000;

endpackage : ppo_pkg

// ==== verilog/ppo_port_pins.sv ====
// Notes on behaviour
// - data-out bit set drives pin high, clear drives low; per-port registers 04h,05h,12h,13h.
// - data-out, direction and address-control registers clear to zero at reset.
// - direction bit set makes pin output, clear makes input; registers 06h,07h,14h,15h.
// - third port keeps bits 7,4,3,2 only; fourth port keeps bits 2,1 only.
// - after reset pins float as inputs unless a logic-array enable term is active.
// - first three ports feed logic inputs via input_macrocell; fourth port feeds directly.
// - first three ports carry output_macrocell outputs; fourth port carries chip selects.
// - a pin assigned to logic output ignores its data-out bit and processor I/O.
// - a logic-input pin stays readable and its direction bit still acts.
// - driver enable is logic-array enable term ORed with the direction bit.
// - an output_macrocell used only internally leaves its pin free for other use.
// - latched-address mode drives demultiplexed address bits on chosen first/second port pins.
// - address-control bits at 02h and 03h select address output per pin.
// - first port bit n carries A[n]; second port carries A[n] or A[n+8].
// - data-in registers 00h,01h,10h,11h return current pin levels.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ppo_port_pins (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    clockEn,
    input  wire ppo_pkg::ppo_av_req_t    avReq,
    output logic [31:0]                  avReadData,
    output logic                         avWaitRequest,
    input  wire logic [15:0]             muxAddrData,
    input  wire logic                    addrStrobe,
    input  wire logic [7:0]              addrHighSel,
    input  wire ppo_pkg::ppo_logic_out_t logicOut,
    output ppo_pkg::ppo_logic_in_t       logicIn,
    input  wire ppo_pkg::ppo_port_bus_t  pinIn,
    output wire ppo_pkg::ppo_port_bus_t  pinOut,
    output wire ppo_pkg::ppo_port_bus_t  pinOe
);
    import ppo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // whole state of the block
    typedef struct packed {
        ppo_port_bus_t   outVal;
        ppo_port_bus_t   dir;
        ppo_port_bus_t   addrCtl;
        logic [15:0]     addrLatch;
        ppo_port_bus_t   syncA;
        ppo_port_bus_t   syncB;
        logic [2:0][7:0] inMacro;
        logic            ack;
        logic [31:0]     readData;
    } ppo_state_t;

    localparam ppo_state_t ST_RESET = '0;

    ppo_state_t  st_q;
    ppo_state_t  st_d;
    logic        busReq;
    logic [5:0]  regIdx;
    logic        aligned;
    logic [31:0] readWord;
    logic [7:0]  wrByte;

    assign busReq  = avReq.read | avReq.write;
    assign regIdx  = avReq.address[7:2];
    assign aligned = (avReq.address[1:0] == 2'b00);
    assign wrByte  = avReq.writedata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the answer; frozen while clockEn low
    assign avWaitRequest = busReq & ~(st_q.ack & clockEn);
    assign avReadData    = st_q.readData;

    // logic-array input bus
    always_comb
    begin
        logicIn.macroIn  = st_q.inMacro;
        logicIn.directIn = st_q.syncB[3];
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode; unmapped or misaligned reads answer zero
    always_comb
    begin
        readWord = READ_ZERO;
        if (!aligned)
            readWord = READ_ZERO;
        else if (regIdx == IDX_IN_A)
            readWord[7:0] = st_q.syncB[0];
        else if (regIdx == IDX_IN_B)
            readWord[7:0] = st_q.syncB[1];
        else if (regIdx == IDX_IN_C)
            readWord[7:0] = st_q.syncB[2] & PORT_MASK[2];
        else if (regIdx == IDX_IN_D)
            readWord[7:0] = st_q.syncB[3] & PORT_MASK[3];
        else if (regIdx == IDX_CTL_A)
            readWord[7:0] = st_q.addrCtl[0];
        else if (regIdx == IDX_CTL_B)
            readWord[7:0] = st_q.addrCtl[1];
        else if (regIdx == IDX_OUT_A)
            readWord[7:0] = st_q.outVal[0];
        else if (regIdx == IDX_OUT_B)
            readWord[7:0] = st_q.outVal[1];
        else if (regIdx == IDX_OUT_C)
            readWord[7:0] = st_q.outVal[2];
        else if (regIdx == IDX_OUT_D)
            readWord[7:0] = st_q.outVal[3];
        else if (regIdx == IDX_DIR_A)
            readWord[7:0] = st_q.dir[0];
        else if (regIdx == IDX_DIR_B)
            readWord[7:0] = st_q.dir[1];
        else if (regIdx == IDX_DIR_C)
            readWord[7:0] = st_q.dir[2];
        else if (regIdx == IDX_DIR_D)
            readWord[7:0] = st_q.dir[3];
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_d = st_q;
        // pins come from outside: two flops before anything looks at them
        st_d.syncA = pinIn;
        st_d.syncB = st_q.syncA;
        // input macrocells register the first three ports
        st_d.inMacro = st_q.syncB[2:0];
        // address latch, separated from the shared bus by the strobe
        if (addrStrobe)
            st_d.addrLatch = muxAddrData;
        // bus: capture read data in the wait cycle, act on the answer edge
        st_d.ack = busReq & ~st_q.ack;
        if (busReq && !st_q.ack && avReq.read)
            st_d.readData = readWord;
        if (st_q.ack && avReq.write && avReq.byteenable[0] && aligned)
        begin
            if (regIdx == IDX_CTL_A)
                st_d.addrCtl[0] = wrByte;
            else if (regIdx == IDX_CTL_B)
                st_d.addrCtl[1] = wrByte;
            else if (regIdx == IDX_OUT_A)
                st_d.outVal[0] = wrByte;
            else if (regIdx == IDX_OUT_B)
                st_d.outVal[1] = wrByte;
            else if (regIdx == IDX_OUT_C)
                st_d.outVal[2] = wrByte & PORT_MASK[2];
            else if (regIdx == IDX_OUT_D)
                st_d.outVal[3] = wrByte & PORT_MASK[3];
            else if (regIdx == IDX_DIR_A)
                st_d.dir[0] = wrByte;
            else if (regIdx == IDX_DIR_B)
                st_d.dir[1] = wrByte;
            else if (regIdx == IDX_DIR_C)
                st_d.dir[2] = wrByte & PORT_MASK[2];
            else if (regIdx == IDX_DIR_D)
                st_d.dir[3] = wrByte & PORT_MASK[3];
        end
    end

    // registers; synchronous reset clears all control state
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            st_q <= ST_RESET;
        else if (clockEn)
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // per-pin output path
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < 4; gp++)
        begin : g_port
            for (gb = 0; gb < 8; gb++)
            begin : g_bit
                logic logicSrc;
                logic addrBit;
                // fourth port carries decode_logic_array chip selects
                if (gp == 3)
                begin : g_cs
                    assign logicSrc = logicOut.chipSel[gb];
                end
                else
                begin : g_mc
                    assign logicSrc = logicOut.macroOut[gp][gb];
                end
                // only the second port may offer the high address byte
                if (gp == 1)
                begin : g_hi
                    assign addrBit = addrHighSel[gb] ? st_q.addrLatch[gb + 8]
                                                     : st_q.addrLatch[gb];
                end
                else
                begin : g_lo
                    assign addrBit = st_q.addrLatch[gb];
                end
                // enable term from the array or the direction bit; firmware must
                // set direction for address pins, nothing here forces it
                assign pinOe[gp][gb] = PORT_MASK[gp][gb]
                    & (logicOut.oeTerm[gp][gb] | st_q.dir[gp][gb]);
                // logic output wins; unassigned macrocells leave the pin free
                assign pinOut[gp][gb] = ~PORT_MASK[gp][gb] ? 1'b0
                    : logicOut.outAssign[gp][gb] ? logicSrc
                    : st_q.addrCtl[gp][gb] ? addrBit
                    : st_q.outVal[gp][gb];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_clears_regs: assert property (
        @(posedge clock) !rst_b |=>
            (st_q.outVal == '0) && (st_q.dir == '0) && (st_q.addrCtl == '0))
        else $error("control registers not cleared by reset");

    a_mcu_pin_level: assert property (
        @(posedge clock) disable iff (!rst_b)
        (logicOut.outAssign[0][3] == 1'b0) && (st_q.addrCtl[0][3] == 1'b0)
            |-> pinOut[0][3] == st_q.outVal[0][3])
        else $error("pin level does not follow data-out bit");

    a_oe_or_term: assert property (
        @(posedge clock) disable iff (!rst_b)
        pinOe == ((logicOut.oeTerm | st_q.dir) & PORT_MASK))
        else $error("driver enable is not enable term or direction");

    a_unused_bits_quiet: assert property (
        @(posedge clock) disable iff (!rst_b)
        ((pinOe[2] | pinOut[2] | st_q.outVal[2] | st_q.dir[2]) & ~PORT_MASK[2]) == 8'h00
            && ((pinOe[3] | st_q.outVal[3] | st_q.dir[3]) & ~PORT_MASK[3]) == 8'h00)
        else $error("unavailable pin position is active");

    a_powerup_hiz: assert property (
        @(posedge clock) (!$past(rst_b) && rst_b && logicOut.oeTerm == '0) |-> pinOe == '0)
        else $error("pin driven after reset without enable term");

    a_macrocell_delay: assert property (
        @(posedge clock) disable iff (!rst_b)
        ($past(clockEn, 1) && $past(clockEn, 2) && $past(clockEn, 3)
            && $past(rst_b, 1) && $past(rst_b, 2) && $past(rst_b, 3))
            |-> logicIn.macroIn == $past(pinIn[2:0], 3)
                && logicIn.directIn == $past(pinIn[3], 2))
        else $error("logic input bus path latency wrong");

    a_logic_out_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        logicOut.outAssign[3][1] |-> ##0 pinOut[3][1] == logicOut.chipSel[1]
            && (logicOut.outAssign[2][7] -> pinOut[2][7] == logicOut.macroOut[2][7]))
        else $error("logic output pin not carrying array output");

    a_addr_high_byte: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q.addrCtl[1][5] && !logicOut.outAssign[1][5] && addrHighSel[5])
            |-> pinOut[1][5] == st_q.addrLatch[13])
        else $error("second port pin not carrying high address bit");

    a_addr_strobe_latch: assert property (
        @(posedge clock) disable iff (!rst_b)
        (addrStrobe && clockEn) |=> st_q.addrLatch == $past(muxAddrData))
        else $error("address not latched on strobe");

    a_write_readback: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.write && !avWaitRequest && avReq.byteenable[0]
            && avReq.address == {IDX_DIR_C, 2'b00})
            |=> st_q.dir[2] == ($past(avReq.writedata[7:0]) & PORT_MASK[2]))
        else $error("direction write not stored with mask");

    a_bus_answer_bound: assert property (
        @(posedge clock) disable iff (!rst_b)
        (busReq && clockEn) |-> ##[0:1] !avWaitRequest)
        else $error("bus answer later than one wait cycle");

    ////////////////////////////////////////////////////////////////////////
    // clock enable, bus framing and further pin routing checks
    a_frozen_state: assert property (
        @(posedge clock) disable iff (!rst_b)
        !clockEn |=> st_q == $past(st_q))
        else $error("state moved while clock enable low");

    a_wait_frozen: assert property (
        @(posedge clock) disable iff (!rst_b)
        (busReq && !clockEn) |-> avWaitRequest)
        else $error("bus answered while clock enable low");

    a_wait_on_request: assert property (
        @(posedge clock) disable iff (!rst_b)
        (busReq && !st_q.ack) |-> avWaitRequest)
        else $error("bus answered without its wait cycle");

    a_ack_one_cycle: assert property (
        @(posedge clock) disable iff (!rst_b)
        (busReq && !avWaitRequest) |=> !st_q.ack)
        else $error("answer held for more than one cycle");

    a_read_upper_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        avReadData[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    a_odd_address_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.read && !avWaitRequest && avReq.address[1:0] != 2'b00)
            |-> avReadData == READ_ZERO)
        else $error("misaligned read did not return zero");

    a_byteen_ignored: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.write && !avWaitRequest && !avReq.byteenable[0])
            |=> st_q.outVal == $past(st_q.outVal) && st_q.dir == $past(st_q.dir)
                && st_q.addrCtl == $past(st_q.addrCtl))
        else $error("write without byte enable changed a register");

    a_data_write_lands: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.write && !avWaitRequest && avReq.byteenable[0]
            && avReq.address == {IDX_OUT_B, 2'b00})
            |=> st_q.outVal[1] == $past(avReq.writedata[7:0]))
        else $error("data-out write not stored");

    a_ctl_write_lands: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.write && !avWaitRequest && avReq.byteenable[0]
            && avReq.address == {IDX_CTL_A, 2'b00})
            |=> st_q.addrCtl[0] == $past(avReq.writedata[7:0]))
        else $error("address control write not stored");

    a_cd_ctl_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        st_q.addrCtl[2] == 8'h00 && st_q.addrCtl[3] == 8'h00)
        else $error("address control set on a port without address mode");

    a_datain_level: assert property (
        @(posedge clock) disable iff (!rst_b)
        (avReq.read && !avWaitRequest && avReq.address == {IDX_IN_B, 2'b00})
            |-> avReadData[7:0] == $past(st_q.syncB[1]))
        else $error("data-in read not the synchronised pin level");

    a_dir_drives: assert property (
        @(posedge clock) disable iff (!rst_b)
        st_q.dir[1][0] |-> pinOe[1][0])
        else $error("direction bit set but pin not driven");

    a_chipsel_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        logicOut.outAssign[3][2] |-> pinOut[3][2] == logicOut.chipSel[2])
        else $error("fourth port pin not carrying chip select");

    a_logic_wins: assert property (
        @(posedge clock) disable iff (!rst_b)
        logicOut.outAssign[1][4] |-> pinOut[1][4] == logicOut.macroOut[1][4])
        else $error("logic output pin not carrying macrocell");

    a_pinout_masked: assert property (
        @(posedge clock) disable iff (!rst_b)
        ((pinOut[2] & ~PORT_MASK[2]) | (pinOut[3] & ~PORT_MASK[3])) == 8'h00)
        else $error("unavailable pin position shows a level");

    a_addr_low_byte: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q.addrCtl[0][6] && !logicOut.outAssign[0][6])
            |-> pinOut[0][6] == st_q.addrLatch[6])
        else $error("first port pin not carrying low address bit");

    a_addr_b_low_sel: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q.addrCtl[1][2] && !logicOut.outAssign[1][2] && !addrHighSel[2])
            |-> pinOut[1][2] == st_q.addrLatch[2])
        else $error("second port pin not carrying low address bit");

endmodule : ppo_port_pins

`default_nettype wire

// ==== test/ppo_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// far-side devices on the port pins; a released pin floats up through a pull-up
module ppo_pin_model (
    input  wire ppo_pkg::ppo_port_bus_t pinOut,
    input  wire ppo_pkg::ppo_port_bus_t pinOe,
    input  wire ppo_pkg::ppo_port_bus_t extVal,
    input  wire ppo_pkg::ppo_port_bus_t extEn,
    output wire ppo_pkg::ppo_port_bus_t pinIn
);
    import ppo_pkg::*;

    // the device driver wins; the far side only drives where the pin is released,
    // so contention never hides a wrong enable
    assign pinIn = (pinOut & pinOe) | (extVal & extEn & ~pinOe) | (~pinOe & ~extEn);

endmodule : ppo_pin_model

`default_nettype wire

// ==== test/test_ppo_port_pins.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_ppo_port_pins;
    import ppo_pkg::*;

    localparam logic [3:0][5:0] OUT_IDX = {IDX_OUT_D, IDX_OUT_C, IDX_OUT_B, IDX_OUT_A};
    localparam logic [3:0][5:0] DIR_IDX = {IDX_DIR_D, IDX_DIR_C, IDX_DIR_B, IDX_DIR_A};
    localparam logic [3:0][5:0] IN_IDX  = {IDX_IN_D, IDX_IN_C, IDX_IN_B, IDX_IN_A};

    logic           clock;
    logic           rst_b;
    logic           clockEn;
    logic           addrStrobe;
    ppo_av_req_t    avReq;
    logic [31:0]    avReadData;
    logic           avWaitRequest;
    logic [15:0]    muxAddrData;
    logic [7:0]     addrHighSel;
    ppo_logic_out_t logicOut;
    ppo_logic_in_t  logicIn;
    wire ppo_port_bus_t pinIn;
    wire ppo_port_bus_t pinOut;
    wire ppo_port_bus_t pinOe;
    ppo_port_bus_t  extVal;
    ppo_port_bus_t  extEn;
    logic [31:0]    rdat;
    int             mismatches;
    int             total_checks;
    int             i;

    ppo_port_pins dut_u (.clock(clock), .rst_b(rst_b), .clockEn(clockEn), .avReq(avReq),
        .avReadData(avReadData), .avWaitRequest(avWaitRequest), .muxAddrData(muxAddrData),
        .addrStrobe(addrStrobe), .addrHighSel(addrHighSel), .logicOut(logicOut),
        .logicIn(logicIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

    ppo_pin_model far_u (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extEn(extEn),
        .pinIn(pinIn));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog; the whole run needs well under a thousand cycles
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic close_out;
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avReq.read       <= ~wr;
        avReq.write      <= wr;
        avReq.address    <= {idx, 2'b00};
        avReq.byteenable <= 4'h1;
        avReq.writedata  <= {24'h00_0000, wd};
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avWaitRequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            mismatches++;
            close_out();
        end
        rdat = avReadData;
        avReq.read  <= 1'b0;
        avReq.write <= 1'b0;
    endtask : bus

    // look at the pins once the last edge's updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        clockEn = 1'b1;
        avReq = '0;
        muxAddrData = 16'h0000;
        addrStrobe = 1'b0;
        addrHighSel = 8'h00;
        logicOut = '0;
        extVal = '0;
        extEn = '0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        // reset values of every writable register, and all pins released
        for (i = 0; i < 4; i++)
        begin
            bus(1'b0, OUT_IDX[i], 8'h00);
            check(rdat, 32'h0000_0000);
            bus(1'b0, DIR_IDX[i], 8'h00);
            check(rdat, 32'h0000_0000);
        end
        bus(1'b0, IDX_CTL_A, 8'h00);
        check(rdat, 32'h0000_0000);
        bus(1'b0, IDX_CTL_B, 8'h00);
        check(rdat, 32'h0000_0000);
        check(pinOe, 32'h0000_0000);
        // all ones in every data-out and direction register: only implemented positions stick
        for (i = 0; i < 4; i++)
        begin
            bus(1'b1, OUT_IDX[i], 8'hFF);
            bus(1'b1, DIR_IDX[i], 8'hFF);
            bus(1'b0, OUT_IDX[i], 8'h00);
            check(rdat, {24'h00_0000, PORT_MASK[i]});
            bus(1'b0, DIR_IDX[i], 8'h00);
            check(rdat, {24'h00_0000, PORT_MASK[i]});
        end
        settle(1);
        check(pinOut, PORT_MASK);
        check(pinOe, PORT_MASK);
        for (i = 0; i < 4; i++)
            bus(1'b1, OUT_IDX[i], 8'h00);
        settle(1);
        check(pinOut, 32'h0000_0000);
        // logic-array outputs override data-out; chip selects on the fourth port
        @(posedge clock);
        logicOut.outAssign <= '1;
        logicOut.macroOut  <= {8'h5A, 8'h3C, 8'hC3};
        logicOut.chipSel   <= 8'hFF;
        settle(1);
        check(pinOut, 32'h0618_3CC3);
        @(posedge clock);
        logicOut.outAssign <= '0;
        settle(1);
        check(pinOut, 32'h0000_0000);
        // enable follows the array term with every direction bit cleared
        for (i = 0; i < 4; i++)
            bus(1'b1, DIR_IDX[i], 8'h00);
        logicOut.oeTerm <= {4{8'h81}};
        settle(1);
        check(pinOe, {4{8'h81}} & PORT_MASK);
        @(posedge clock);
        logicOut.oeTerm <= '0;
        extVal <= {4{8'h5A}};
        extEn  <= '1;
        // inputs from the far side reach data-in and the logic-input bus
        settle(4);
        for (i = 0; i < 4; i++)
        begin
            bus(1'b0, IN_IDX[i], 8'h00);
            check(rdat, {24'h00_0000, 8'h5A & PORT_MASK[i]});
        end
        check(logicIn.macroIn[1], 8'h5A);
        check(logicIn.directIn & 8'h06, 8'h02);
        // direction still acts on a pin that feeds the array
        bus(1'b1, IDX_OUT_A, 8'h33);
        bus(1'b1, IDX_DIR_A, 8'hFF);
        settle(4);
        check(logicIn.macroIn[0], 8'h33);
        bus(1'b0, IDX_IN_A, 8'h00);
        check(rdat, 32'h0000_0033);
        // unmapped index: write dropped, read gives zero
        bus(1'b1, 6'h08, 8'hFF);
        bus(1'b0, 6'h08, 8'h00);
        check(rdat, 32'h0000_0000);
        // latched address: low byte on the first port, high byte on the second
        addrHighSel <= 8'h0F;
        muxAddrData <= 16'hA5C3;
        bus(1'b1, IDX_DIR_B, 8'hFF);
        bus(1'b1, IDX_CTL_A, 8'hF0);
        bus(1'b1, IDX_CTL_B, 8'h0F);
        addrStrobe <= 1'b1;
        @(posedge clock);
        addrStrobe <= 1'b0;
        muxAddrData <= 16'h0000;
        settle(1);
        check(pinOut[0], 8'hC3);
        check(pinOut[1], 8'h05);
        bus(1'b1, IDX_CTL_A, 8'h00);
        settle(1);
        check(pinOut[0], 8'h33);
        // clock enable low: a strobe is ignored and the latch keeps its address
        clockEn     <= 1'b0;
        muxAddrData <= 16'h1234;
        addrStrobe  <= 1'b1;
        settle(2);
        addrStrobe  <= 1'b0;
        clockEn     <= 1'b1;
        settle(1);
        check(pinOut[1], 8'h05);
        bus(1'b0, IDX_CTL_B, 8'h00);
        check(rdat, 32'h0000_000F);
        close_out();
    end

endmodule : test_ppo_port_pins

`default_nettype wire
